/* apn_pkg.sv */
// Shared constants and carrier types for the alternate protocol
// negotiation block. Assumes one 250 MHz clock and a synchronous reset.
// Overview of operation
// - Protocol code field sent as zero.
// - Host drives shared reference clock flag.
// - Caps in phase one, result in two.
// - Bypass capability advertised, decision sent later.
// - Unaware retimers mean bypass is unsupported.
// - Result is base or alternate, never both.
// - Two hardware phases across configuration substates.
// - Phase one: stream caps, partner answers.
// - Phase two: stream mode and enabled protocols.
// - Done before first L0; then report mode.
// - Features turn on only at 8GT/s L0.
// - Alternate mode below 8GT/s fails link.
// - Advertise 32GT/s while negotiating at 2.5GT/s; the code does so only when CB_COH is set.
// - Afterwards advertise the true maximum rate.
// - Compatible degradation keeps mode without renegotiation.
// - Incompatible degradation: detect, then base mode.
// - Mode selection and info bit positions.
// - Usage field 010b marks negotiation sets.
package apn_pkg;

  // Training set field values
  localparam logic [2:0]  USAGE_ALT       = 3'h2;
  localparam logic [2:0]  ALT_ID_COHERENT = 3'h0;
  // Arbitrary neutral value for the protocol owner code
  localparam logic [15:0] OWNER_CODE      = 16'h0a5a;

  // Bit positions inside the 24-bit mode field
  localparam int MS_BASE    = 0;
  localparam int MS_IO      = 1;
  localparam int MS_MEM     = 2;
  localparam int MS_CACHE   = 3;
  localparam int BIT_BYPASS = 10;
  localparam int BIT_RT1    = 12;
  localparam int BIT_RT2    = 14;
  // Bits the partner must echo in phase two
  localparam logic [23:0] ECHO_MASK = 24'h00040f;

  // Link rate codes
  localparam logic [2:0] RATE_2G5 = 3'h0;
  localparam logic [2:0] RATE_8G  = 3'h2;
  localparam logic [2:0] RATE_32G = 3'h4;

  // Identical sets needed before a received set counts
  localparam logic [3:0] TS_CONSEC = 4'h8;

  // Register byte offsets
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_RATE = 4'h4;
  localparam logic [3:0] ADDR_STAT = 4'h8;
  localparam logic [3:0] ADDR_PART = 4'hc;

  // Control register fields and reset values
  localparam int CB_BASE  = 0;
  localparam int CB_IO    = 1;
  localparam int CB_MEM   = 2;
  localparam int CB_CACHE = 3;
  localparam int CB_BYP   = 4;
  localparam int CB_CCLK  = 5;
  localparam int CB_RT1   = 6;
  localparam int CB_RT2   = 7;
  localparam int CB_COH   = 8;
  localparam int CB_CLRFB = 9;
  localparam logic [8:0] CTRL_RST = 9'h11f;
  localparam logic [2:0] RATE_RST = RATE_32G;

  // Training state reported by the base link trainer
  typedef enum logic [2:0] {
    LT_DETECT, LT_LN_WAIT, LT_LN_ACC, LT_CFG_CPL, LT_L0, LT_RECOV,
    LT_OTHER
  } apn_ltssm_t;

  // Negotiation progress
  typedef enum logic [2:0] {
    ST_IDLE, ST_PH1, ST_PH2, ST_DONE, ST_FAIL
  } apn_neg_t;

  // Negotiation fields of a modified training set
  typedef struct packed {
    logic        isTs2;
    logic [2:0]  usage;
    logic [1:0]  negStatus;
    logic [2:0]  altProtocolCode;
    logic        commonClk;
    logic [15:0] ownerCode;
    logic [23:0] modeInfo;
  } apn_ts_t;

  // Link status from the base trainer
  typedef struct packed {
    apn_ltssm_t  state;
    logic [2:0]  rate;
    logic        compat;
    logic        speedDone;
  } apn_link_t;

  // Chosen mode
  typedef struct packed {
    logic baseMode;
    logic coherent;
    logic io;
    logic mem;
    logic cache;
    logic bypass;
  } apn_mode_t;

  // Avalon-MM request from the master
  typedef struct packed {
    logic        read;
    logic        write;
    logic [3:0]  address;
    logic [31:0] writedata;
  } apn_avm_req_t;

endpackage

/* apn_ts_qual.sv */
// Counts identical received training sets in a row.
// Assumes inputs come from logic on the same clock.
`timescale 1ns/1ns
module apn_ts_qual (
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic valid,
  input  wire logic match,
  input  wire logic clear,
  output wire logic hit
);
  import apn_pkg::*;

  logic [3:0] cnt_q;  // Saturating run length

  // A mismatching set restarts the run, guarding against noise
  always_ff @(posedge clock) begin
    if (reset || clear) begin
      cnt_q <= 4'h0;
    end else if (valid) begin
      if (!match) begin
        cnt_q <= 4'h0;
      end else if (cnt_q != TS_CONSEC) begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end

  assign hit = (cnt_q == TS_CONSEC);

endmodule

/* apn_mode_neg.sv */
// Alternate protocol negotiation for the host end of a link.
// Assumes trainer status and received sets on this clock.
`timescale 1ns/1ns
module apn_mode_neg (
  input  wire logic                  clock,
  input  wire logic                  reset,
  input  wire apn_pkg::apn_avm_req_t avReq,
  output wire logic [31:0]           avReaddata,
  output wire logic                  avWaitrequest,
  input  wire apn_pkg::apn_link_t    link,
  input  wire logic                  rxValid,
  input  wire apn_pkg::apn_ts_t      rxTs,
  output wire apn_pkg::apn_ts_t      txTs,
  output wire logic                  txModified,
  output wire logic [2:0]            advRate,
  output wire apn_pkg::apn_mode_t    modeReport,
  output wire logic                  modeValid,
  output wire apn_pkg::apn_mode_t    featureOn,
  output wire logic                  linkFail,
  output wire logic                  detectReq
);
  import apn_pkg::*;

  // Build the mode field from single flags
  function automatic logic [23:0] mkInfo(input logic b, input logic i,
      input logic m, input logic c, input logic y);
    logic [23:0] v;
    v = 24'h0;
    v[MS_BASE] = b;
    v[MS_IO] = i;
    v[MS_MEM] = m;
    v[MS_CACHE] = c;
    v[BIT_BYPASS] = y;
    return v;
  endfunction

  logic        ack_q;          // Bus answer cycle
  logic [31:0] readdata_q;     // Read data
  logic [8:0]  ctrl_q;         // Capability and retimer control
  logic [2:0]  trueRate_q;     // True maximum rate
  logic        fallback_q;     // Forced base mode after degradation
  logic [23:0] partnerInfo_q;  // Partner phase one field
  logic [23:0] decInfo_q;      // Decision sent in phase two
  apn_neg_t    negSt_q;        // Negotiation state
  apn_neg_t    negSt_d;
  apn_mode_t   mode_q;         // Latched mode
  apn_mode_t   featOn_q;       // Live features
  apn_ts_t     txTs_q;         // Outgoing set
  logic        txMod_q;        // Modified sets active
  logic [2:0]  advRate_q;      // Advertised rate
  logic        detectReq_q;    // Ask trainer to go to detect

  // Bus slave: one wait cycle, then answer
  wire busReq = avReq.read | avReq.write;
  wire wrEn   = avReq.write & ack_q;
  wire hitCtrl = (avReq.address == ADDR_CTRL);
  wire hitRate = (avReq.address == ADDR_RATE);
  wire hitStat = (avReq.address == ADDR_STAT);
  wire hitPart = (avReq.address == ADDR_PART);
  wire [31:0] statWord = {20'h0, negSt_q, linkFail, fallback_q,
                          detectReq_q, mode_q};
  // Unmapped addresses read zero
  wire [31:0] rdMux = hitCtrl ? {23'h0, ctrl_q} :
                      hitRate ? {29'h0, trueRate_q} :
                      hitStat ? statWord :
                      hitPart ? {8'h0, partnerInfo_q} : 32'h0;
  assign avWaitrequest = busReq & ~ack_q;
  assign avReaddata    = readdata_q;

  // Answer strobe and read capture
  always_ff @(posedge clock) begin
    if (reset) begin
      ack_q      <= 1'b0;
      readdata_q <= 32'h0;
    end else begin
      ack_q <= busReq & ~ack_q;
      if (avReq.read && !ack_q) begin
        readdata_q <= rdMux;
      end
    end
  end

  // Software control; presence set before training
  always_ff @(posedge clock) begin
    if (reset) begin
      ctrl_q     <= CTRL_RST;
      trueRate_q <= RATE_RST;
    end else if (wrEn && hitCtrl) begin
      ctrl_q <= avReq.writedata[8:0];
    end else if (wrEn && hitRate) begin
      trueRate_q <= avReq.writedata[2:0];
    end
  end

  // Decision terms
  wire coh   = ctrl_q[CB_COH] & ~fallback_q;
  wire agIo  = coh & ctrl_q[CB_IO] & partnerInfo_q[MS_IO];
  wire agMem = agIo & ctrl_q[CB_MEM] & partnerInfo_q[MS_MEM];
  wire agCa  = agIo & ctrl_q[CB_CACHE] & partnerInfo_q[MS_CACHE];
  // Present but unaware retimers veto bypass
  wire rtOk = (~ctrl_q[CB_RT1] | partnerInfo_q[BIT_RT1]) &
              (~ctrl_q[CB_RT2] | partnerInfo_q[BIT_RT2]);
  wire agByp = agIo & ctrl_q[CB_BYP] & ctrl_q[CB_CCLK] &
               partnerInfo_q[BIT_BYPASS] & rtOk;
  // Base only when alternate not agreed
  wire agBase = ~agIo & ctrl_q[CB_BASE] & partnerInfo_q[MS_BASE];
  wire [23:0] decInfo = mkInfo(agBase, agIo, agMem, agCa, agByp);
  wire [23:0] capInfo = mkInfo(ctrl_q[CB_BASE], coh & ctrl_q[CB_IO],
                               coh & ctrl_q[CB_MEM],
                               coh & ctrl_q[CB_CACHE],
                               coh & ctrl_q[CB_BYP]);

  // Received set qualification
  wire rxAlt = rxValid & (rxTs.usage == USAGE_ALT) &
               (rxTs.altProtocolCode == ALT_ID_COHERENT);
  wire ts1Match = rxAlt & ~rxTs.isTs2 &
                  (rxTs.modeInfo == partnerInfo_q);
  // Partner must echo our enables
  wire ts2Match = rxAlt & rxTs.isTs2 &
                  ((rxTs.modeInfo & ECHO_MASK) == (decInfo_q & ECHO_MASK));
  wire ts1Hit;
  wire ts2Hit;

  apn_ts_qual uQualTs1 (
    .clock (clock),
    .reset (reset),
    .valid (rxValid),
    .match (ts1Match),
    .clear (negSt_q != ST_PH1),
    .hit   (ts1Hit)
  );

  apn_ts_qual uQualTs2 (
    .clock (clock),
    .reset (reset),
    .valid (rxValid),
    .match (ts2Match),
    .clear (negSt_q != ST_PH2),
    .hit   (ts2Hit)
  );

  wire inLanenum = (link.state == LT_LN_WAIT) ||
                   (link.state == LT_LN_ACC);
  wire rateOk    = (link.rate >= RATE_8G);
  // Alternate mode that cannot reach 8GT/s
  wire speedBad  = mode_q.coherent & link.speedDone & ~rateOk;
  // Degradation the alternate mode cannot live with
  wire incompat  = (negSt_q == ST_DONE) & mode_q.coherent &
                   ~link.compat;

  // Negotiation sequence across configuration substates
  always_comb begin
    negSt_d = negSt_q;
    case (negSt_q)
      ST_IDLE: begin
        if (inLanenum) begin
          negSt_d = ST_PH1;
        end
      end
      ST_PH1: begin
        if (link.state == LT_CFG_CPL) begin
          negSt_d = ts1Hit ? ST_PH2 : ST_DONE;
        end else if (link.state == LT_L0) begin
          negSt_d = ST_DONE;
        end
      end
      ST_PH2: begin
        if (ts2Hit) begin
          negSt_d = ST_DONE;
        end else if (link.state == LT_L0) begin
          negSt_d = ST_FAIL;
        end
      end
      ST_DONE: begin
        // Recovery keeps the mode
        if (speedBad) begin
          negSt_d = ST_FAIL;
        end
      end
      default: begin
        negSt_d = negSt_q;
      end
    endcase
    if (link.state == LT_DETECT) begin
      negSt_d = ST_IDLE;
    end
  end

  // State register
  always_ff @(posedge clock) begin
    if (reset) begin
      negSt_q <= ST_IDLE;
    end else begin
      negSt_q <= negSt_d;
    end
  end

  // Partner caps frozen once qualified
  always_ff @(posedge clock) begin
    if (reset || negSt_q == ST_IDLE) begin
      partnerInfo_q <= 24'h0;
    end else if (negSt_q == ST_PH1 && rxAlt && !rxTs.isTs2 && !ts1Hit) begin
      partnerInfo_q <= rxTs.modeInfo;
    end
  end

  // Decision frozen on entry to phase two
  always_ff @(posedge clock) begin
    if (reset || negSt_q == ST_IDLE) begin
      decInfo_q <= 24'h0;
    end else if (negSt_q == ST_PH1 && negSt_d == ST_PH2) begin
      decInfo_q <= decInfo;
    end
  end

  // Mode latched on entry to done from phase two or phase one, held until detect
  always_ff @(posedge clock) begin
    if (reset || negSt_q == ST_IDLE) begin
      mode_q <= '0;
    end else if (negSt_q == ST_PH2 && negSt_d == ST_DONE) begin
      mode_q <= '{baseMode: decInfo_q[MS_BASE],
                  coherent: decInfo_q[MS_IO],
                  io:       decInfo_q[MS_IO],
                  mem:      decInfo_q[MS_MEM],
                  cache:    decInfo_q[MS_CACHE],
                  bypass:   decInfo_q[BIT_BYPASS]};
    end else if (negSt_q == ST_PH1 && negSt_d == ST_DONE) begin
      // Phase one ended at completion without a qualified partner set, or at L0: plain base mode
      mode_q <= '{baseMode: ctrl_q[CB_BASE], default: 1'b0};
    end
  end

  // Features go live only in L0 at 8GT/s or more
  always_ff @(posedge clock) begin
    if (reset || negSt_q != ST_DONE) begin
      featOn_q <= '0;
    end else if (mode_q.coherent && link.state == LT_L0 && rateOk) begin
      featOn_q <= mode_q;
    end
  end

  // Degradation fallback; set wins over software clear
  always_ff @(posedge clock) begin
    if (reset) begin
      fallback_q <= 1'b0;
    end else if (incompat) begin
      fallback_q <= 1'b1;
    end else if (wrEn && hitCtrl && avReq.writedata[CB_CLRFB]) begin
      fallback_q <= 1'b0;
    end
  end

  // Detect request held until trainer reaches detect
  always_ff @(posedge clock) begin
    if (reset || link.state == LT_DETECT) begin
      detectReq_q <= 1'b0;
    end else if (incompat) begin
      detectReq_q <= 1'b1;
    end
  end

  // Outgoing set; phase one caps, phase two result
  always_ff @(posedge clock) begin
    if (reset) begin
      txTs_q  <= '0;
      txMod_q <= 1'b0;
    end else begin
      txMod_q                <= (negSt_d == ST_PH1) || (negSt_d == ST_PH2);
      txTs_q.isTs2           <= (negSt_d == ST_PH2);
      txTs_q.usage           <= USAGE_ALT;
      txTs_q.negStatus       <= 2'h0;
      txTs_q.altProtocolCode <= ALT_ID_COHERENT;
      txTs_q.commonClk       <= ctrl_q[CB_CCLK];
      txTs_q.ownerCode       <= OWNER_CODE;
      // Phase two carries the frozen decision
      txTs_q.modeInfo <= (negSt_d == ST_PH2) ?
                         ((negSt_q == ST_PH1) ? decInfo : decInfo_q) :
                         capInfo;
    end
  end

  // Rate advertising; 32GT/s until negotiation ends when CB_COH is set
  always_ff @(posedge clock) begin
    if (reset) begin
      advRate_q <= RATE_32G;
    end else if (negSt_d == ST_PH1 || negSt_d == ST_PH2 ||
                 (negSt_d == ST_IDLE && ctrl_q[CB_COH])) begin
      advRate_q <= ctrl_q[CB_COH] ? RATE_32G : trueRate_q;
    end else begin
      advRate_q <= trueRate_q;
    end
  end

  assign txTs       = txTs_q;
  assign txModified = txMod_q;
  assign advRate    = advRate_q;
  assign modeReport = mode_q;
  assign modeValid  = (negSt_q == ST_DONE);
  assign featureOn  = featOn_q;
  assign linkFail   = (negSt_q == ST_FAIL);
  assign detectReq  = detectReq_q;

  // Checks
  property p_code;
    @(posedge clock) disable iff (reset)
    txModified |-> txTs.altProtocolCode == ALT_ID_COHERENT &&
                   txTs.usage == USAGE_ALT;
  endproperty
  a_code: assert property (p_code) else $error("bad code");

  property p_cclk;
    @(posedge clock) disable iff (reset)
    txModified && $stable(ctrl_q) |-> txTs.commonClk == ctrl_q[CB_CCLK];
  endproperty
  a_cclk: assert property (p_cclk) else $error("bad clk flag");

  property p_ts2;
    @(posedge clock) disable iff (reset)
    negSt_q == ST_PH2 && $past(negSt_q) == ST_PH2 |->
      txTs.isTs2 && txTs.modeInfo == decInfo_q;
  endproperty
  a_ts2: assert property (p_ts2) else $error("bad phase two");

  property p_excl;
    @(posedge clock) disable iff (reset)
    modeValid |-> !(modeReport.baseMode && modeReport.coherent);
  endproperty
  a_excl: assert property (p_excl) else $error("both modes");

  property p_byp;
    @(posedge clock) disable iff (reset)
    modeValid && modeReport.bypass |-> rtOk && ctrl_q[CB_CCLK];
  endproperty
  a_byp: assert property (p_byp) else $error("bypass veto lost");

  property p_feat;
    @(posedge clock) disable iff (reset)
    $rose(featureOn.coherent) |->
      $past(link.rate) >= RATE_8G && $past(link.state) == LT_L0;
  endproperty
  a_feat: assert property (p_feat) else $error("early feature");

  property p_speed;
    @(posedge clock) disable iff (reset)
    modeValid && speedBad && link.state != LT_DETECT |=> linkFail;
  endproperty
  a_speed: assert property (p_speed) else $error("no fail");

  property p_rate;
    @(posedge clock) disable iff (reset)
    negSt_q == ST_PH1 && ctrl_q[CB_COH] ##1 negSt_q == ST_PH1 |->
      advRate == RATE_32G;
  endproperty
  a_rate: assert property (p_rate) else $error("rate not 32G");

  property p_hold;
    @(posedge clock) disable iff (reset)
    modeValid && $past(modeValid) |-> $stable(modeReport);
  endproperty
  a_hold: assert property (p_hold) else $error("mode moved");

  property p_degr;
    @(posedge clock) disable iff (reset)
    incompat && link.state != LT_DETECT |=> detectReq && fallback_q;
  endproperty
  a_degr: assert property (p_degr) else $error("no fallback");

  c_coh: cover property (@(posedge clock) $rose(featureOn.coherent));
  c_base: cover property (@(posedge clock)
    modeValid && modeReport.baseMode);
  c_fail: cover property (@(posedge clock) $rose(linkFail));
  c_byp: cover property (@(posedge clock) modeValid && modeReport.bypass);

endmodule

/* apn_partner.sv */
// Endpoint model on the far side of the negotiation link.
// Assumes the host's sets arrive on the same clock; answers every gap+1
// cycles while the host sends modified sets.
`timescale 1ns/1ns
module apn_partner (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire apn_pkg::apn_ts_t txTs,
  input  wire logic             txModified,
  input  wire logic [23:0]      epCaps,
  input  wire logic [1:0]       gap,
  input  wire logic             badEcho,
  output apn_pkg::apn_ts_t      rxTs,
  output logic                  rxValid
);
  import apn_pkg::*;

  logic [1:0] cnt_q;  // Cycles since the last set sent

  // One set per gap+1 cycles; idle cycles scramble the bus so a stale
  // value is never mistaken for a fresh set
  always_ff @(posedge clock) begin
    if (reset) begin
      cnt_q   <= 2'h0;
      rxValid <= 1'b0;
      rxTs    <= '0;
    end else if (txModified && cnt_q >= gap) begin
      cnt_q                <= 2'h0;
      rxValid              <= 1'b1;
      rxTs.isTs2           <= txTs.isTs2;
      rxTs.usage           <= USAGE_ALT;
      rxTs.negStatus       <= 2'h0;
      rxTs.altProtocolCode <= ALT_ID_COHERENT;
      rxTs.commonClk       <= txTs.commonClk;
      rxTs.ownerCode       <= OWNER_CODE;
      // Phase one answers caps; retimer awareness bits ride in epCaps
      // and no retimer adds bypass on the way up
      // Phase two echoes the decision, bypass relayed unchanged
      rxTs.modeInfo <= txTs.isTs2 ?
        (txTs.modeInfo & ECHO_MASK) ^ {23'h0, badEcho} : epCaps;
    end else begin
      cnt_q   <= cnt_q + 2'h1;
      rxValid <= 1'b0;
      rxTs    <= ~rxTs;
    end
  end
endmodule

/* test_apn_mode_neg.sv */
// Self-checking bench for the host negotiation block.
// Assumes the endpoint model apn_partner and a 250 MHz clock.
`timescale 1ns/1ns
module test_apn_mode_neg;
  import apn_pkg::*;

  // Table row: control word, endpoint caps, expected mode
  typedef struct packed {
    logic [8:0]  ctrl;
    logic [23:0] ep;
    logic [5:0]  exp;
  } apn_row_t;

  logic         clock;
  logic         reset;
  apn_avm_req_t avReq;
  logic [31:0]  avReaddata;
  logic         avWaitrequest;
  apn_link_t    link;
  logic         rxValid;
  apn_ts_t      rxTs;
  apn_ts_t      txTs;
  logic         txModified;
  logic [2:0]   advRate;
  apn_mode_t    modeReport;
  logic         modeValid;
  apn_mode_t    featureOn;
  logic         linkFail;
  logic         detectReq;
  logic [23:0]  epCaps;      // Endpoint phase-one answer
  logic [1:0]   gap;         // Partner pacing
  logic         badEcho;     // Partner corrupts its echo
  logic [31:0]  q;           // Last read word
  int           checked   = 0;
  int           badCount  = 0;
  int           cycles    = 0;
  // Caps, retimer awareness and bypass outcomes in one sweep
  apn_row_t rows [7] = '{
    '{9'h11f, 24'h00040f, 6'h1e}, '{9'h13f, 24'h00040f, 6'h1f},
    '{9'h17f, 24'h00040f, 6'h1e}, '{9'h17f, 24'h00140f, 6'h1f},
    '{9'h13f, 24'h000403, 6'h19}, '{9'h13f, 24'h000001, 6'h20},
    '{9'h1bf, 24'h00140f, 6'h1e}};

  apn_mode_neg i_dut (.clock(clock), .reset(reset), .avReq(avReq),
    .avReaddata(avReaddata), .avWaitrequest(avWaitrequest), .link(link),
    .rxValid(rxValid), .rxTs(rxTs), .txTs(txTs), .txModified(txModified),
    .advRate(advRate), .modeReport(modeReport), .modeValid(modeValid),
    .featureOn(featureOn), .linkFail(linkFail), .detectReq(detectReq));

  apn_partner i_partner (.clock(clock), .reset(reset), .txTs(txTs),
    .txModified(txModified), .epCaps(epCaps), .gap(gap),
    .badEcho(badEcho), .rxTs(rxTs), .rxValid(rxValid));

  // Free-running clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // Hang guard, well above the longest expected run
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      badCount++;
      stop_test();
    end
  end

  task automatic stop_test;
    if (badCount == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      badCount++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One bus cycle; held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    avReq <= '{read: !wr, write: wr, address: a, writedata: d};
    @(posedge clock);
    while (avWaitrequest !== 1'b0) @(posedge clock);
    q = avReaddata;
    avReq <= '0;
    @(posedge clock);
  endtask

  // Back to detect; fail, detect request and mode valid must drop
  task automatic to_detect;
    link <= '{LT_DETECT, RATE_2G5, 1'b1, 1'b0};
    repeat (3) @(posedge clock);
    check({linkFail, detectReq, modeValid}, 0);
  endtask

  // Both phases with the partner answering
  task automatic negotiate(input apn_row_t r, input logic bad);
    bus(1'b1, ADDR_CTRL, {23'h0, r.ctrl});
    epCaps  <= r.ep;
    badEcho <= bad;
    link.state <= LT_LN_WAIT;
    while (txModified !== 1'b1) @(posedge clock);
    check(txTs.usage, USAGE_ALT);
    check(txTs.altProtocolCode, ALT_ID_COHERENT);
    check(txTs.commonClk, r.ctrl[CB_CCLK]);
    check(txTs.ownerCode, OWNER_CODE);
    check({txTs.isTs2, txTs.modeInfo[14], txTs.modeInfo[12]}, 0);
    if (r.exp[4]) begin
      check(txTs.modeInfo[3:0], r.ctrl[3:0]);
      check(txTs.modeInfo[BIT_BYPASS], r.ctrl[CB_BYP]);
      check(advRate, RATE_32G);
    end
    repeat (60) @(posedge clock);
    check(modeValid, 0);
    link.state <= LT_CFG_CPL;
    while (txTs.isTs2 !== 1'b1) @(posedge clock);
    // Decision is base or alternate, never both
    check(txTs.modeInfo[3:0], {r.exp[1],r.exp[2],r.exp[3],r.exp[5]});
    check(txTs.modeInfo[BIT_BYPASS], r.exp[0]);
    if (!bad) while (modeValid !== 1'b1) @(posedge clock);
  endtask

  initial begin
    reset  = 1'b1;
    avReq  = '0;
    link   = '{LT_DETECT, RATE_2G5, 1'b1, 1'b0};
    epCaps = 24'h0;
    gap    = 2'h0;
    badEcho = 1'b0;
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    check({txModified, modeValid, advRate}, {2'b00, RATE_32G});
    // Register reset values, read-only and unmapped places
    bus(1'b0, ADDR_CTRL, 32'h0);
    check(q, 32'h11f);
    bus(1'b1, ADDR_STAT, 32'hffffffff);
    bus(1'b0, ADDR_STAT, 32'h0);
    check(q, 32'h0);
    bus(1'b0, 4'h2, 32'h0);
    check(q, 32'h0);
    bus(1'b1, ADDR_RATE, {29'h0, RATE_8G});
    // Table sweep with the partner paced fast and slow
    for (int i = 0; i < 7; i++) begin
      gap <= i[1:0];
      negotiate(rows[i], 1'b0);
      check(modeReport, rows[i].exp);
      check(advRate, RATE_8G);
      bus(1'b0, ADDR_PART, 32'h0);
      check(q, {8'h0, rows[i].ep});
      bus(1'b0, ADDR_STAT, 32'h0);
      check(q, {20'h0, 6'h18, rows[i].exp});
      link.state <= LT_L0;
      repeat (3) @(posedge clock);
      check(featureOn, 0);
      link.rate <= RATE_8G;
      repeat (2) @(posedge clock);
      check(featureOn, rows[i].exp[4] ? rows[i].exp : 6'h0);
      check(modeReport, rows[i].exp);
      to_detect();
    end
    // Wrong echo, then L0 while still in phase two
    negotiate(rows[1], 1'b1);
    repeat (30) @(posedge clock);
    check(modeValid, 0);
    link.state <= LT_L0;
    repeat (2) @(posedge clock);
    check(linkFail, 1);
    to_detect();
    // Alternate mode stuck at the lowest rate
    negotiate(rows[0], 1'b0);
    link <= '{LT_L0, RATE_2G5, 1'b1, 1'b1};
    repeat (3) @(posedge clock);
    check({linkFail, featureOn}, {1'b1, 6'h0});
    to_detect();
    // Compatible degradation keeps mode, incompatible falls back
    negotiate(rows[0], 1'b0);
    link <= '{LT_L0, RATE_8G, 1'b1, 1'b0};
    repeat (3) @(posedge clock);
    link.state <= LT_RECOV;
    repeat (3) @(posedge clock);
    link.state <= LT_L0;
    repeat (2) @(posedge clock);
    check({detectReq, modeValid, modeReport}, {2'b01, 6'h1e});
    link.compat <= 1'b0;
    repeat (3) @(posedge clock);
    check(detectReq, 1);
    to_detect();
    negotiate('{9'h13f, 24'h00040f, 6'h20}, 1'b0);
    check(modeReport, 6'h20);
    bus(1'b0, ADDR_STAT, 32'h0);
    check(q[7], 1);
    bus(1'b1, ADDR_CTRL, 32'h33f);
    to_detect();
    negotiate(rows[0], 1'b0);
    check(modeReport, 6'h1e);
    to_detect();
    // Partner too slow to qualify before completion: plain base mode
    gap <= 2'h3;
    link.state <= LT_LN_ACC;
    while (txModified !== 1'b1) @(posedge clock);
    link.state <= LT_CFG_CPL;
    while (modeValid !== 1'b1) @(posedge clock);
    check({modeReport, txModified}, {6'h20, 1'b0});
    to_detect();
    // Reset in mid phase two drops everything
    negotiate(rows[1], 1'b1);
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    link  <= '{LT_DETECT, RATE_2G5, 1'b1, 1'b0};
    @(posedge clock);
    check({txModified, modeValid, modeReport}, 0);
    check(advRate, RATE_32G);
    bus(1'b0, ADDR_CTRL, 32'h0);
    check(q, 32'h11f);
    stop_test();
  end
endmodule
